// ### hw/lfs_capture.sv
`timescale 1ns/1ps
module lfs_capture
	import lfs_pkg::*;
#(
	parameter int WAKE_CYCLES = WAKE_CYC
) (
	// Clock and reset
	input  wire logic                sys_clk_in,
	input  wire logic                rst_n_in,
	// Serial link pins
	input  wire logic                shift_clk_in,
	input  wire logic                serial_in_in,
	input  wire logic                latch_strobe_in,
	input  wire logic                blank_in,
	output logic                     serial_out_out,
	// Analog comparator results per channel, then global thermal and reference short flags
	input  wire logic [CHAN_N-1:0]   open_cmp_in,
	input  wire logic [CHAN_N-1:0]   short_cmp_in,
	input  wire logic [CHAN_N-1:0]   leak_cmp_in,
	input  wire logic                thermal_shutdown_in,
	input  wire logic                pre_thermal_warning_in,
	input  wire logic                ref_short_flag_in,
	// Oscillator tick
	input  wire logic                osc_tick_in,
	// Status to analog core
	output logic [CHAN_N-1:0]        onoff_out,
	output logic [1:0]               short_threshold_sel_out,
	output logic [1:0]               invisible_current_sel_out,
	output logic                     invisible_sink_out,
	output logic                     leak_source_out,
	output logic                     power_save_out,
	output logic [CHAN_N-1:0]        status_word_out
);

	// ==========================================================
	// Signals
	logic [SHIFT_W-1:0] shift_ff;
	logic [CHAN_N-1:0]  onoff_ff;
	logic [15:0]        ctrl_ff;
	logic [CHAN_N-1:0]  holder_ff;
	logic               ps_ff;
	logic               serial_out_ff;
	logic               tef_ff;
	logic               ptw_ff;
	logic [15:0]        wake_cnt_ff;
	logic [3:0]         settle_cnt_ff;

	// Edge detector history
	logic               sclk_d_ff;
	logic               lat_d_ff;
	logic               blank_d_ff;

	// Synchronised comparator results and pins
	logic [CHAN_N-1:0]  open_s;
	logic [CHAN_N-1:0]  short_s;
	logic [CHAN_N-1:0]  leak_s;
	logic [5:0]         pin_s;
	logic               sclk_s;
	logic               sin_s;
	logic               lat_s;
	logic               blank_s;
	logic               blank_n_s;
	logic               tsd_s;
	logic               ptw_s;
	logic               isf_s;

	// One-cycle edge strobes
	logic               sclk_rise;
	logic               lat_rise;
	logic               blank_rise;
	logic               blank_fall;

	// Decoded control and qualification
	logic [1:0]         sel;
	logic               idm_en;
	logic               det_ok;

	// Per-channel qualified results
	logic [CHAN_N-1:0]  open_v;
	logic [CHAN_N-1:0]  short_v;
	logic [CHAN_N-1:0]  leak_v;

	// Next-state values
	logic [CHAN_N-1:0]  nxt_holder;
	logic [CHAN_N-1:0]  nxt_onoff;
	logic [15:0]        nxt_ctrl;
	logic               cap_now;

	lfs_cap_if cap ();

	// ==========================================================
	// Synchronisers: pins and comparator results
	// Comparators are analog and may settle at any moment
	lfs_sync #(.W(3 * CHAN_N)) u_cmp_sync (
		.clk_in  (sys_clk_in),
		.rst_n_in(rst_n_in),
		.d_in    ({open_cmp_in, short_cmp_in, leak_cmp_in}),
		.q_out   ({open_s, short_s, leak_s})
	);

	// Shift clock and data share one synchroniser so they stay aligned
	lfs_sync #(.W(6)) u_pin_sync (
		.clk_in  (sys_clk_in),
		.rst_n_in(rst_n_in),
		.d_in    ({shift_clk_in, serial_in_in, latch_strobe_in,
		           thermal_shutdown_in, pre_thermal_warning_in, ref_short_flag_in}),
		.q_out   (pin_s)
	);

	// Blank idles high; carried inverted so the synchroniser's reset
	// value matches the idle level and no false edge follows reset
	lfs_sync #(.W(1)) u_blank_sync (
		.clk_in  (sys_clk_in),
		.rst_n_in(rst_n_in),
		.d_in    (~blank_in),
		.q_out   (blank_n_s)
	);

	assign blank_s = ~blank_n_s;
	assign {sclk_s, sin_s, lat_s, tsd_s, ptw_s, isf_s} = pin_s;

	// Edge detect on synchronised levels
	// History resets to each pin's idle level
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sclk_d_ff  <= 1'b0;
			lat_d_ff   <= 1'b0;
			blank_d_ff <= 1'b1;
		end else begin
			sclk_d_ff  <= sclk_s;
			lat_d_ff   <= lat_s;
			blank_d_ff <= blank_s;
		end
	end

	assign sclk_rise  = sclk_s & ~sclk_d_ff;
	assign lat_rise   = lat_s & ~lat_d_ff;
	assign blank_rise = blank_s & ~blank_d_ff;
	assign blank_fall = ~blank_s & blank_d_ff;

	// ==========================================================
	// Control fields
	assign sel    = ctrl_ff[SEL_LSB +: 2];
	assign idm_en = (ctrl_ff[CUR_LSB +: 2] != CUR_OFF);

	// Latched fields and state out to the analog core
	assign short_threshold_sel_out   = ctrl_ff[THR_LSB +: 2];
	assign invisible_current_sel_out = ctrl_ff[CUR_LSB +: 2];
	assign onoff_out                 = onoff_ff;
	assign power_save_out            = ps_ff;
	assign status_word_out           = holder_ff;
	assign serial_out_out            = serial_out_ff;

	// ==========================================================
	// Invisible detection window
	// Held off in power-save; a blank rise ends it early
	assign cap.run_start = idm_en && blank_fall && !ps_ff;
	assign cap.run_stop  = blank_rise;
	assign cap.tim_sel   = ctrl_ff[TIM_LSB +: 2];

	lfs_idm_win u_win (
		.clk_in     (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.osc_tick_in(osc_tick_in),
		.cap        (cap)
	);

	assign invisible_sink_out = cap.active;
	// Leak source only with leakage select, blank low, no invisible mode
	assign leak_source_out = (sel == SEL_LEAK) && !blank_s && !idm_en && !ps_ff;

	// ==========================================================
	// Settling after blank falls or outputs change; wake delay after power-save
	// Comparators swing while outputs switch, so captures wait it out
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settle_cnt_ff <= 4'h0;
		end else if (blank_fall || (lat_rise && !shift_ff[SHIFT_W-1])) begin
			settle_cnt_ff <= 4'(BLANK_CYC);
		end else if (settle_cnt_ff != 4'h0) begin
			settle_cnt_ff <= settle_cnt_ff - 4'h1;
		end
	end

	// Reloaded throughout power-save; counts down once awake
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wake_cnt_ff <= 16'h0000;
		end else if (ps_ff) begin
			wake_cnt_ff <= 16'(WAKE_CYCLES);
		end else if (wake_cnt_ff != 16'h0000) begin
			wake_cnt_ff <= wake_cnt_ff - 16'h0001;
		end
	end

	// Detection only valid when awake and settled
	// A capture attempted too early is dropped, not delayed
	assign det_ok = !ps_ff && (wake_cnt_ff == 16'h0000) && (settle_cnt_ff == 4'h0);

	// ==========================================================
	// Per-channel qualification
	// Off channels read 0 unless invisible mode sinks a test current;
	// leakage is only meaningful on channels that are switched off
	for (genvar gi = 0; gi < CHAN_N; gi++) begin : g_chan
		assign open_v[gi]  = open_s[gi] && (onoff_ff[gi] || idm_en);
		assign short_v[gi] = short_s[gi] && (onoff_ff[gi] || idm_en);
		assign leak_v[gi]  = leak_s[gi] && !onoff_ff[gi];
	end

	// Status word chosen by select; flags override to all ones
	// Reference short is a live level and is not held
	always_comb begin
		case (sel)
			SEL_OPEN:  nxt_holder = tef_ff ? {CHAN_N{1'b1}} : open_v;
			SEL_SHORT: nxt_holder = ptw_ff ? {CHAN_N{1'b1}} : short_v;
			SEL_LEAK:  nxt_holder = isf_s ? {CHAN_N{1'b1}} : leak_v;
			default:   nxt_holder = holder_ff;
		endcase
	end

	// Capture moment: blank rise normally, window end in invisible mode
	// Leakage has no window of its own and always waits for blank
	always_comb begin
		if (idm_en && sel != SEL_LEAK)
			cap_now = cap.active && (cap.expired || cap.run_stop);
		else
			cap_now = blank_rise;
	end

	// ==========================================================
	// Status holder; invalid results are not captured
	// Changes only at a capture moment, so a read between two
	// captures always returns one consistent snapshot
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			holder_ff <= '0;
		end else if (cap_now && det_ok && sel != SEL_NONE) begin
			holder_ff <= nxt_holder;
		end
	end

	// ==========================================================
	// Thermal flags: set by condition, held until next latch strobe.
	// Set wins over the strobe clear so no event is lost.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tef_ff <= 1'b0;
			ptw_ff <= 1'b0;
		end else begin
			if (tsd_s)
				tef_ff <= 1'b1;
			else if (lat_rise)
				tef_ff <= 1'b0;
			if (ptw_s)
				ptw_ff <= 1'b1;
			else if (lat_rise)
				ptw_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Latch contents after the current strobe
	// Power-save looks at these values, not at the registers
	always_comb begin
		nxt_onoff = onoff_ff;
		nxt_ctrl  = ctrl_ff;
		if (lat_rise) begin
			if (shift_ff[SHIFT_W-1])
				nxt_ctrl = shift_ff[15:0];
			else
				nxt_onoff = shift_ff[CHAN_N-1:0];
		end
	end

	// On/off and control latches
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			onoff_ff <= ONOFF_RST;
			ctrl_ff  <= CTRL_RST;
		end else begin
			onoff_ff <= nxt_onoff;
			ctrl_ff  <= nxt_ctrl;
		end
	end

	// ==========================================================
	// Shift register; serial_out changes on shift clock rising edge and on a strobe that reloads the status word
	// Control writes skip the reload, so such a frame reads back as sent
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shift_ff <= '0;
			serial_out_ff  <= 1'b0;
		end else if (sclk_rise) begin
			shift_ff <= {shift_ff[SHIFT_W-2:0], sin_s};
			serial_out_ff  <= shift_ff[SHIFT_W-1];
		end else if (lat_rise && !shift_ff[SHIFT_W-1] && sel != SEL_NONE) begin
			shift_ff[CHAN_N-1:0] <= holder_ff;
			serial_out_ff              <= shift_ff[SHIFT_W-1];
		end
	end

	// ==========================================================
	// Power-save: evaluated on the freshly updated latches.
	// Wake time for analog core is the host's to respect.
	// A shift clock edge wins over a strobe in the same cycle
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ps_ff <= 1'b0;
		end else if (sclk_rise) begin
			ps_ff <= 1'b0;
		end else if (lat_rise && nxt_ctrl[PS_BIT] && nxt_onoff == '0) begin
			ps_ff <= 1'b1;
		end else if (!nxt_ctrl[PS_BIT]) begin
			ps_ff <= 1'b0;
		end
	end

endmodule // lfs_capture

// ### hw/lfs_idm_win.sv
`timescale 1ns/1ps
module lfs_idm_win
	import lfs_pkg::*;
(
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// Oscillator tick
	input  wire logic osc_tick_in,
	// Control
	lfs_cap_if.win    cap
);
	lfs_win_t   state_ff;
	logic [7:0] cnt_ff;
	logic [7:0] lim;

	// Working time in oscillator clocks
	always_comb begin
		case (cap.tim_sel)
			2'h0:    lim = 8'(IDM_T0);
			2'h1:    lim = 8'(IDM_T1);
			2'h2:    lim = 8'(IDM_T2);
			default: lim = 8'(IDM_T3);
		endcase
	end

	assign cap.active  = (state_ff == WIN_RUN);
	assign cap.expired = (state_ff == WIN_RUN) && osc_tick_in && (cnt_ff == lim - 8'h01);

	// ==========================================================
	// Window; blank rising ends it early
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= WIN_IDLE;
			cnt_ff   <= 8'h00;
		end else begin
			case (state_ff)
				WIN_IDLE: begin
					cnt_ff <= 8'h00;
					if (cap.run_start)
						state_ff <= WIN_RUN;
				end
				WIN_RUN: begin
					if (cap.run_stop || cap.expired)
						state_ff <= WIN_DONE;
					else if (osc_tick_in)
						cnt_ff <= cnt_ff + 8'h01;
				end
				WIN_DONE: begin
					if (!cap.run_start)
						state_ff <= WIN_IDLE;
				end
				default: state_ff <= WIN_IDLE;
			endcase
		end
	end
endmodule // lfs_idm_win

// ### hw/lfs_sync.sv
`timescale 1ns/1ps
module lfs_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	// Data
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_ff;

	// ==========================================================
	// Two-stage synchroniser; first stage is read only by second
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_ff <= '0;
			q_out   <= '0;
		end else begin
			meta_ff <= d_in;
			q_out   <= meta_ff;
		end
	end
endmodule // lfs_sync

// ### pkg/lfs_cap_if.sv
`timescale 1ns/1ps
interface lfs_cap_if;
	logic        run_start;
	logic        run_stop;
	logic [1:0]  tim_sel;
	logic        active;
	logic        expired;

	modport ctl (output run_start, output run_stop, output tim_sel, input active, input expired);
	modport win (input run_start, input run_stop, input tim_sel, output active, output expired);
endinterface

// ### pkg/lfs_pkg.sv
package lfs_pkg;

	// ==========================================================
	// Widths
	localparam int CHAN_N      = 16;
	localparam int SHIFT_W     = 17;

	// ==========================================================
	// Field encodings
	localparam logic [1:0] SEL_NONE  = 2'h0;
	localparam logic [1:0] SEL_OPEN  = 2'h1;
	localparam logic [1:0] SEL_SHORT = 2'h2;
	localparam logic [1:0] SEL_LEAK  = 2'h3;
	localparam logic [1:0] CUR_OFF   = 2'h0;

	// ==========================================================
	// Reset values of the control and on/off latches, and control field positions (power-save on, rest per defaults)
	localparam logic [15:0] CTRL_RST   = 16'he67f;
	localparam logic [15:0] ONOFF_RST  = 16'h0000;
	localparam int          SEL_LSB    = 7;
	localparam int          THR_LSB    = 9;
	localparam int          CUR_LSB    = 11;
	localparam int          TIM_LSB    = 13;
	localparam int          PS_BIT     = 15;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ         = 20;
	localparam int BLANK_NS        = 500;
	localparam int BLANK_CYC       = (BLANK_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_US         = 20;
	localparam int WAKE_CYC        = WAKE_US * CLK_MHZ;
	localparam int IDM_T0          = 17;
	localparam int IDM_T1          = 33;
	localparam int IDM_T2          = 65;
	localparam int IDM_T3          = 129;
	localparam int OSC_DIV         = 1;

	// Window states
	typedef enum logic [1:0] {
		WIN_IDLE = 2'b00,
		WIN_RUN  = 2'b01,
		WIN_DONE = 2'b10
	} lfs_win_t;

endpackage

// ### verif/led_fault_status_capture_tb.sv
`timescale 1ns/1ps
// ==========
// Testbench
module led_fault_status_capture_tb;
	import lfs_pkg::*;
	localparam int WAKE = 4;
	logic sys_clk = 1'b0, rst_n = 1'b0, osc = 1'b0, blank = 1'b1;
	logic sclk, sdin, lat, serial_out, sink, leak_src, ps, thermal_shutdown = 1'b0, pre_thermal_warning = 1'b0, ref_short_flag = 1'b0, mid_leak;
	logic [15:0] open_cmp = 16'h3c5a, short_cmp = 16'h81e7, leak_cmp = 16'h6900, onoff, status;
	logic [1:0] thr, cur;
	logic [16:0] rd;
	int num_errors = 0, compares = 0, cycles = 0;

	always #25 sys_clk = ~sys_clk;
	// Oscillator tick every second cycle
	always @(negedge sys_clk) osc <= ~osc;

	lfs_capture #(.WAKE_CYCLES(WAKE)) u_dut (
		.sys_clk_in(sys_clk), .rst_n_in(rst_n), .shift_clk_in(sclk), .serial_in_in(sdin),
		.latch_strobe_in(lat), .blank_in(blank), .serial_out_out(serial_out), .open_cmp_in(open_cmp),
		.short_cmp_in(short_cmp), .leak_cmp_in(leak_cmp), .thermal_shutdown_in(thermal_shutdown),
		.pre_thermal_warning_in(pre_thermal_warning), .ref_short_flag_in(ref_short_flag), .osc_tick_in(osc), .onoff_out(onoff),
		.short_threshold_sel_out(thr), .invisible_current_sel_out(cur), .invisible_sink_out(sink),
		.leak_source_out(leak_src), .power_save_out(ps), .status_word_out(status)
	);
	lfs_host #(.WAKE_CYCLES(WAKE)) u_host (
		.sys_clk_in(sys_clk), .shift_clk_out(sclk), .serial_data_out(sdin), .latch_out(lat),
		.serial_out_in(serial_out)
	);

	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			close_out();
		end
	end

	task automatic close_out();
		$display("Compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic nclk(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	function automatic logic [16:0] ctl(logic pse, logic [1:0] tim, logic [1:0] cu, logic [1:0] sel);
		return {1'b1, pse, tim, cu, sel, sel, 7'h7f};
	endfunction

	task automatic wr(input logic [16:0] w);
		u_host.frame(w, rd);
	endtask

	// Blank pulse long enough to pass the settle time
	task automatic capture();
		nclk(12);
		blank = 1'b0;
		nclk(20);
		mid_leak = leak_src;
		blank = 1'b1;
		nclk(6);
	endtask

	task automatic t_power_save();
		check("cur reset", {15'h0, cur}, 17'h0);
		wr(17'h01234);
		wr(ctl(1'b1, 2'h3, CUR_OFF, SEL_NONE));
		check("sel none readback", rd, 17'h01234);
		check("onoff latch", {1'b0, onoff}, 17'h01234);
		check("ps with on", {16'h0, ps}, 17'h0);
		wr(17'h00000);
		check("ps enter", {16'h0, ps}, 17'h1);
		u_host.wake();
		check("ps exit", {16'h0, ps}, 17'h0);
		wr(ctl(1'b1, 2'h3, CUR_OFF, SEL_NONE));
		check("ps ctrl write", {16'h0, ps}, 17'h1);
		wr(ctl(1'b0, 2'h3, CUR_OFF, SEL_NONE));
		wr(17'h00000);
		check("ps disabled", {16'h0, ps}, 17'h0);
	endtask

	task automatic t_select();
		logic [15:0] exp_w;
		wr(17'h000ff);
		for (int s = 1; s < 4; s++) begin
			for (int f = 0; f < 2; f++) begin
				exp_w = (s == 1) ? open_cmp & 16'h00ff : (s == 2) ? short_cmp & 16'h00ff : leak_cmp & ~16'h00ff;
				exp_w = f ? 16'hffff : exp_w;
				wr(ctl(1'b0, 2'h3, CUR_OFF, 2'(s)));
				check("threshold", {15'h0, thr}, 17'(s));
				thermal_shutdown = (f == 1 && s == 1);
				pre_thermal_warning = (f == 1 && s == 2);
				ref_short_flag = (f == 1 && s == 3);
				capture();
				check("leak source", {16'h0, mid_leak}, 17'(s == 3));
				check("holder", {1'b0, status}, {1'b0, exp_w});
				thermal_shutdown = 1'b0;
				pre_thermal_warning = 1'b0;
				ref_short_flag = 1'b0;
				if (f == 1 && s < 3) begin
					capture();
					check("flag held", {1'b0, status}, 17'h0ffff);
				end
				wr(17'h000ff);
				wr(17'h000ff);
				check("readback", rd, {1'b0, exp_w});
			end
		end
	endtask

	task automatic t_idm();
		int cnt, len;
		for (int t = 0; t < 4; t++) begin
			len = (t == 0) ? IDM_T0 : (t == 1) ? IDM_T1 : (t == 2) ? IDM_T2 : IDM_T3;
			wr(ctl(1'b0, 2'(t), 2'h1, SEL_OPEN));
			check("idm current", {15'h0, cur}, 17'h1);
			open_cmp = 16'hc3a5 ^ 16'(t);
			nclk(12);
			blank = 1'b0;
			cnt = 0;
			repeat (2 * len + 40) begin
				@(negedge sys_clk);
				cnt += int'(sink);
			end
			check("sink time", {16'h0, cnt >= 2 * len - 3 && cnt <= 2 * len + 3}, 17'h1);
			check("sink stopped", {16'h0, sink}, 17'h0);
			check("idm holder", {1'b0, status}, {1'b0, open_cmp});
			blank = 1'b1;
			nclk(6);
		end
	endtask

	// Main sequence
	initial begin
		nclk(2);
		rst_n = 1'b1;
		nclk(4);
		t_power_save();
		t_select();
		t_idm();
		close_out();
	end
endmodule // led_fault_status_capture_tb

// ### verif/lfs_checker.sv
`timescale 1ns/1ps
// ==========
// Port checker
module lfs_chk
	import lfs_pkg::*;
(
	// Clock and reset
	input wire logic              sys_clk_in,
	input wire logic              rst_n_in,
	// Pins
	input wire logic              shift_clk_in,
	input wire logic              latch_strobe_in,
	input wire logic              blank_in,
	input wire logic              osc_tick_in,
	input wire logic              serial_out_out,
	// Core side
	input wire logic [CHAN_N-1:0] onoff_out,
	input wire logic [1:0]        invisible_current_sel_out,
	input wire logic              invisible_sink_out,
	input wire logic              power_save_out,
	input wire logic [CHAN_N-1:0] status_word_out
);
	logic [3:0] lat_age_ff, blk_age_ff, sclk_age_ff;
	logic [7:0] tick_cnt_ff;

	function automatic logic [3:0] age(logic ev, logic [3:0] a);
		return ev ? 4'h0 : a + {3'h0, a != 4'hf};
	endfunction

	// Cycles since pin edges; pins reach the core through synchronisers
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lat_age_ff <= 4'hf;
			blk_age_ff <= 4'hf;
			sclk_age_ff <= 4'hf;
		end else begin
			lat_age_ff <= age($rose(latch_strobe_in), lat_age_ff);
			blk_age_ff <= age($rose(blank_in), blk_age_ff);
			sclk_age_ff <= age($rose(shift_clk_in), sclk_age_ff);
		end
	end

	// Oscillator ticks in the running window
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			tick_cnt_ff <= 8'h00;
		else if (!invisible_sink_out)
			tick_cnt_ff <= 8'h00;
		else
			tick_cnt_ff <= tick_cnt_ff + {7'h00, osc_tick_in};
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_idm_fall;
		$fell(blank_in) && invisible_current_sel_out != CUR_OFF && !power_save_out;
	endsequence
	sequence s_sink_up;
		##[1:8] invisible_sink_out;
	endsequence

	a_sink_start: assert property (s_idm_fall |-> s_sink_up) else $error("sink did not start");
	a_sink_needs_cur: assert property (invisible_sink_out |-> invisible_current_sel_out != CUR_OFF)
		else $error("sink without current");
	a_sink_off_blank: assert property (blank_in [*8] |-> !invisible_sink_out) else $error("sink in blank");
	a_ticks_bounded: assert property (tick_cnt_ff <= 8'h82) else $error("window too long");
	a_ps_from_latch: assert property ($rose(power_save_out) |-> lat_age_ff <= 4'h8)
		else $error("power save without latch");
	a_ps_onoff_zero: assert property (power_save_out |-> onoff_out == '0) else $error("power save with on");
	a_ps_exit_shift: assert property (power_save_out && $rose(shift_clk_in) |-> ##[1:6] !power_save_out)
		else $error("power save kept");
	a_status_capture: assert property ($changed(status_word_out) |-> blk_age_ff <= 4'h8 || $fell(invisible_sink_out))
		else $error("holder changed");
	a_onoff_on_latch: assert property ($changed(onoff_out) |-> lat_age_ff <= 4'h6)
		else $error("onoff changed");
	a_serial_out_on_shift: assert property ($changed(serial_out_out) |-> sclk_age_ff <= 4'h6 || lat_age_ff <= 4'h6)
		else $error("serial out changed");
endmodule // lfs_chk

bind lfs_capture lfs_chk u_chk (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .shift_clk_in(shift_clk_in),
	.latch_strobe_in(latch_strobe_in), .blank_in(blank_in), .osc_tick_in(osc_tick_in),
	.serial_out_out(serial_out_out), .onoff_out(onoff_out),
	.invisible_current_sel_out(invisible_current_sel_out), .invisible_sink_out(invisible_sink_out),
	.power_save_out(power_save_out), .status_word_out(status_word_out)
);

// ### verif/lfs_host.sv
`timescale 1ns/1ps
// ==========
// Host controller model
module lfs_host #(
	parameter int WAKE_CYCLES = 4
) (
	// Clock
	input wire logic sys_clk_in,
	// Link pins
	output logic     shift_clk_out,
	output logic     serial_data_out,
	output logic     latch_out,
	input wire logic serial_out_in
);
	// Shift clock parked low between frames
	initial begin
		shift_clk_out = 1'b0;
		serial_data_out = 1'b0;
		latch_out = 1'b0;
	end

	task automatic nclk(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask

	// 17 bits MSB first at 400 ns; each bit read before the next rise
	task automatic frame(input logic [16:0] w, output logic [16:0] r);
		for (int i = 16; i >= 0; i--) begin
			serial_data_out = w[i];
			shift_clk_out = 1'b1;
			nclk(4);
			shift_clk_out = 1'b0;
			nclk(3);
			r[i] = serial_out_in;
			nclk(1);
		end
		serial_data_out = ~w[0]; // Released line must not keep the last bit
		latch_out = 1'b1;
		nclk(4);
		latch_out = 1'b0;
		nclk(12);
	endtask

	// Single shift clock rise, then hold off until the core is awake
	task automatic wake();
		shift_clk_out = 1'b1;
		nclk(4);
		shift_clk_out = 1'b0;
		nclk(WAKE_CYCLES + 6);
	endtask
endmodule // lfs_host
